// >>> include/sec_rx_cfg.svh
`ifndef SEC_RX_CFG_SVH
`define SEC_RX_CFG_SVH

`define RX_CH5_ROUTE_OFS  8'h2C
`define RX_CH6_ROUTE_OFS  8'h2D
`define RX_CH7_ROUTE_OFS  8'h2E
`define RX_CH5_ROUTE_RST  8'h04
`define RX_CH6_ROUTE_RST  8'h05
`define RX_CH7_ROUTE_RST  8'h06
`define RSVD_BIT          7
`define SRC_SEL_MSB       6
`define SRC_SEL_LSB       5
`define SLOT_IDX_MSB      4
`define SLOT_IDX_LSB      0
`define SRC_DISABLED      2'h0
`define SRC_PLAYBACK      2'h1
`define SRC_LOOPBACK      2'h2
`define SRC_CHAIN         2'h3
`define FMT_TDM           2'h0
`define FMT_I2S           2'h1
`define FMT_LJ            2'h2
`define LEFT_SLOT_BASE    5'h00
`define RIGHT_SLOT_BASE   5'h10
`define WORD_BITS         32
`endif

// >>> include/sec_rx_pkg.sv
`include "sec_rx_cfg.svh"
package sec_rx_pkg;
  typedef logic [1:0] src_sel_t;
  typedef logic [4:0] slot_idx_t;

  typedef struct packed {
    logic      rsvd;
    src_sel_t  source;
    slot_idx_t slot;
  } route_cfg_t;

  typedef struct packed {
    src_sel_t                dest;
    logic [`WORD_BITS-1:0]   data;
  } routed_word_t;

  typedef enum logic {LINK_IDLE, LINK_FRAMED} link_state_t;
endpackage

// >>> rtl/route_skid_buf.sv
module route_skid_buf #(
  parameter int W = 34
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  logic [W-1:0] e0_r;
  logic [W-1:0] e1_r;
  logic         v0_r;
  logic         v1_r;
  logic         push;
  logic         pop;

  assign push        = in_valid_i & ~v1_r;
  assign pop         = v0_r & out_ready_i;
  assign in_ready_o  = ~v1_r;
  assign out_valid_o = v0_r;
  assign out_data_o  = e0_r;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      e0_r <= '0;
      e1_r <= '0;
      v0_r <= 1'b0;
      v1_r <= 1'b0;
    end
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          if (!v0_r)
          begin
            e0_r <= in_data_i;
            v0_r <= 1'b1;
          end
          else
          begin
            e1_r <= in_data_i;
            v1_r <= 1'b1;
          end
        end
        2'b01:
        begin
          e0_r <= e1_r;
          v0_r <= v1_r;
          v1_r <= 1'b0;
        end
        // push implies second entry empty, so the new word becomes head
        2'b11: e0_r <= in_data_i;
        default: ;
      endcase
    end
  end
endmodule

// >>> rtl/sec_rx_slot_map.sv
`include "sec_rx_cfg.svh"
module sec_rx_slot_map (
  input  wire logic                          CORE_CLK_I,
  input  wire logic                          NRST_I,
  input  wire logic                          BCLK_I,
  input  wire logic                          FSYNC_I,
  input  wire logic                          DIN_I,
  input  wire logic [1:0]                    FMT_I,
  input  wire logic [7:0]                    REG_ADDR_I,
  input  wire logic                          REG_WE_I,
  input  wire logic [7:0]                    REG_WDATA_I,
  output logic      [7:0]                    REG_RDATA_O,
  output logic      [2:0]                    RX_VALID_O,
  output sec_rx_pkg::routed_word_t [2:0]     RX_WORD_O,
  input  wire logic [2:0]                    RX_READY_I
);
  localparam int CNT_W = $clog2(`WORD_BITS);
  localparam int WW    = $bits(sec_rx_pkg::routed_word_t);
  localparam logic [7:0] OFS [3] = '{`RX_CH5_ROUTE_OFS, `RX_CH6_ROUTE_OFS, `RX_CH7_ROUTE_OFS};
  localparam logic [7:0] RST [3] = '{`RX_CH5_ROUTE_RST, `RX_CH6_ROUTE_RST, `RX_CH7_ROUTE_RST};

  // ---------------- link domain ----------------
  logic [1:0]                  lrst_r;
  logic                        lnrst;
  logic [1:0]                  fmt_s1_r;
  logic [1:0]                  fmt_s2_r;
  logic                        fs_d_r;
  logic                        bnd_d_r;
  sec_rx_pkg::slot_idx_t       bnd_slot_d_r;
  logic                        bnd_raw;
  sec_rx_pkg::slot_idx_t       raw_slot;
  logic                        bnd;
  sec_rx_pkg::slot_idx_t       bnd_slot;
  logic                        is_i2s;
  sec_rx_pkg::link_state_t     link_st_r;
  logic [CNT_W-1:0]            bit_cnt_r;
  logic [`WORD_BITS-1:0]       shift_r;
  sec_rx_pkg::slot_idx_t       slot_r;
  logic [`WORD_BITS-1:0]       hold_data_r;
  sec_rx_pkg::slot_idx_t       hold_slot_r;
  logic                        tog_r;
  logic                        last_bit;
  logic [`WORD_BITS-1:0]       shift_nxt;

  // reset asserts at once, releases on the link clock
  always_ff @(posedge BCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      lrst_r <= 2'h0;
    else
      lrst_r <= {lrst_r[0], 1'b1};
  end
  assign lnrst = lrst_r[1];

  always_ff @(posedge BCLK_I or negedge lnrst)
  begin
    if (!lnrst)
    begin
      fmt_s1_r <= 2'h0;
      fmt_s2_r <= 2'h0;
    end
    else
    begin
      fmt_s1_r <= FMT_I;
      fmt_s2_r <= fmt_s1_r;
    end
  end

  assign is_i2s = (fmt_s2_r == `FMT_I2S);

  // frame and half-frame boundaries per format
  always_comb
  begin
    bnd_raw  = 1'b0;
    raw_slot = `LEFT_SLOT_BASE;
    case (fmt_s2_r)
      `FMT_I2S:
      begin
        bnd_raw  = FSYNC_I ^ fs_d_r;
        raw_slot = FSYNC_I ? `RIGHT_SLOT_BASE : `LEFT_SLOT_BASE;
      end
      `FMT_LJ:
      begin
        bnd_raw  = FSYNC_I ^ fs_d_r;
        raw_slot = FSYNC_I ? `LEFT_SLOT_BASE : `RIGHT_SLOT_BASE;
      end
      default:
      begin
        bnd_raw  = FSYNC_I & ~fs_d_r;
        raw_slot = `LEFT_SLOT_BASE;
      end
    endcase
  end

  // i2s data starts one bit clock after the frame edge
  assign bnd      = is_i2s ? bnd_d_r : bnd_raw;
  assign bnd_slot = is_i2s ? bnd_slot_d_r : raw_slot;
  assign last_bit = (bit_cnt_r == CNT_W'(`WORD_BITS - 1));
  assign shift_nxt = {shift_r[`WORD_BITS-2:0], DIN_I};

  always_ff @(posedge BCLK_I or negedge lnrst)
  begin
    if (!lnrst)
    begin
      fs_d_r       <= 1'b0;
      bnd_d_r      <= 1'b0;
      bnd_slot_d_r <= '0;
    end
    else
    begin
      fs_d_r       <= FSYNC_I;
      bnd_d_r      <= bnd_raw;
      bnd_slot_d_r <= raw_slot;
    end
  end

  always_ff @(posedge BCLK_I or negedge lnrst)
  begin
    if (!lnrst)
    begin
      link_st_r   <= sec_rx_pkg::LINK_IDLE;
      bit_cnt_r   <= '0;
      shift_r     <= '0;
      slot_r      <= '0;
      hold_data_r <= '0;
      hold_slot_r <= '0;
      tog_r       <= 1'b0;
    end
    else
    begin
      case (link_st_r)
        sec_rx_pkg::LINK_IDLE:
        begin
          if (bnd)
          begin
            link_st_r <= sec_rx_pkg::LINK_FRAMED;
            bit_cnt_r <= CNT_W'(1);
            shift_r   <= shift_nxt;
            slot_r    <= bnd_slot;
          end
        end
        sec_rx_pkg::LINK_FRAMED:
        begin
          shift_r <= shift_nxt;
          if (bnd)
          begin
            bit_cnt_r <= CNT_W'(1);
            slot_r    <= bnd_slot;
          end
          else if (last_bit)
          begin
            hold_data_r <= shift_nxt;
            hold_slot_r <= slot_r;
            tog_r       <= ~tog_r;
            slot_r      <= slot_r + 5'h01;
            bit_cnt_r   <= '0;
          end
          else
            bit_cnt_r <= bit_cnt_r + CNT_W'(1);
        end
        default: link_st_r <= sec_rx_pkg::LINK_IDLE;
      endcase
    end
  end

  // ---------------- core domain ----------------
  logic                        tog_s1_r;
  logic                        tog_s2_r;
  logic                        tog_s3_r;
  logic                        arr_vld_r;
  logic [`WORD_BITS-1:0]       arr_data_r;
  sec_rx_pkg::slot_idx_t       arr_slot_r;
  sec_rx_pkg::route_cfg_t      cfg_r [3];
  logic [7:0]                  rdata_nxt;

  // held word is stable for a whole slot, so it is taken on the toggle edge
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      tog_s1_r   <= 1'b0;
      tog_s2_r   <= 1'b0;
      tog_s3_r   <= 1'b0;
      arr_vld_r  <= 1'b0;
      arr_data_r <= '0;
      arr_slot_r <= '0;
    end
    else
    begin
      tog_s1_r  <= tog_r;
      tog_s2_r  <= tog_s1_r;
      tog_s3_r  <= tog_s2_r;
      arr_vld_r <= tog_s2_r ^ tog_s3_r;
      if (tog_s2_r ^ tog_s3_r)
      begin
        arr_data_r <= hold_data_r;
        arr_slot_r <= hold_slot_r;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      for (int k = 0; k < 3; k++)
        cfg_r[k] <= sec_rx_pkg::route_cfg_t'(RST[k]);
    end
    else if (REG_WE_I)
    begin
      for (int k = 0; k < 3; k++)
        if (REG_ADDR_I == OFS[k])
          cfg_r[k] <= sec_rx_pkg::route_cfg_t'({1'b0, REG_WDATA_I[`SRC_SEL_MSB:0]});
    end
  end

  always_comb
  begin
    rdata_nxt = 8'h00;
    for (int k = 0; k < 3; k++)
      if (REG_ADDR_I == OFS[k])
        rdata_nxt = {1'b0, cfg_r[k].source, cfg_r[k].slot};
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      REG_RDATA_O <= 8'h00;
    else
      REG_RDATA_O <= rdata_nxt;
  end

  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_ch
      logic                     enabled;
      logic                     match;
      logic                     buf_rdy;
      logic                     pend_vld_r;
      sec_rx_pkg::routed_word_t pend_word_r;
      logic [WW-1:0]            out_raw;

      // channel 5 has no chain source: treat it as disabled
      assign enabled = (cfg_r[i].source != `SRC_DISABLED) &&
                       !(i == 0 && cfg_r[i].source == `SRC_CHAIN);
      assign match   = arr_vld_r && enabled && (arr_slot_r == cfg_r[i].slot);

      // full buffer stalls the pending word; a later match then is dropped
      always_ff @(posedge CORE_CLK_I or negedge NRST_I)
      begin
        if (!NRST_I)
        begin
          pend_vld_r  <= 1'b0;
          pend_word_r <= '0;
        end
        else if (!pend_vld_r || buf_rdy)
        begin
          pend_vld_r <= match;
          if (match)
          begin
            pend_word_r.dest <= cfg_r[i].source;
            pend_word_r.data <= arr_data_r;
          end
        end
      end

      route_skid_buf #(
        .W (WW)
      ) u_buf (
        .clk_i       (CORE_CLK_I),
        .nrst_i      (NRST_I),
        .in_valid_i  (pend_vld_r),
        .in_data_i   (pend_word_r),
        .in_ready_o  (buf_rdy),
        .out_valid_o (RX_VALID_O[i]),
        .out_data_o  (out_raw),
        .out_ready_i (RX_READY_I[i])
      );

      assign RX_WORD_O[i] = sec_rx_pkg::routed_word_t'(out_raw);
    end
  endgenerate
endmodule

// >>> tb/sec_rx_slot_map_chk.sv
module sec_rx_slot_map_chk (
  input wire logic                           CORE_CLK_I,
  input wire logic                           NRST_I,
  input wire logic [7:0]                     REG_ADDR_I,
  input wire logic                           REG_WE_I,
  input wire logic [7:0]                     REG_WDATA_I,
  input wire logic [7:0]                     REG_RDATA_O,
  input wire logic [2:0]                     RX_VALID_O,
  input wire sec_rx_pkg::routed_word_t [2:0] RX_WORD_O,
  input wire logic [2:0]                     RX_READY_I
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!NRST_I);
  logic mapped;
  assign mapped = REG_ADDR_I inside {8'h2C, 8'h2D, 8'h2E};
  sequence s_wr_held;
    REG_WE_I && mapped ##1 $stable(REG_ADDR_I) && !REG_WE_I;
  endsequence
  property p_hold(int i);
    RX_VALID_O[i] && !RX_READY_I[i] |=> RX_VALID_O[i] && $stable(RX_WORD_O[i]);
  endproperty
  chk_rsvd_zero: assert property (REG_RDATA_O[7] == 1'b0)
    else $error("reserved read bit set");
  chk_write_back: assert property (s_wr_held |=> REG_RDATA_O == {1'b0, $past(REG_WDATA_I[6:0], 2)})
    else $error("write not read back");
  chk_reset_idle: assert property ($rose(NRST_I) |-> RX_VALID_O == 3'h0 && REG_RDATA_O == 8'h00)
    else $error("outputs busy after reset");
  chk_reset_value: assert property ($rose(NRST_I) && REG_ADDR_I == 8'h2C |=> REG_RDATA_O == 8'h04)
    else $error("wrong reset value");
  chk_hold_ch5: assert property (p_hold(0))
    else $error("ch5 word lost under stall");
  chk_hold_ch6: assert property (p_hold(1))
    else $error("ch6 word lost under stall");
  chk_hold_ch7: assert property (p_hold(2))
    else $error("ch7 word lost under stall");
  chk_ch5_dest: assert property (RX_VALID_O[0] |-> RX_WORD_O[0].dest inside {2'h1, 2'h2})
    else $error("ch5 bad destination");
  chk_ch6_live: assert property (RX_VALID_O[1] |-> RX_WORD_O[1].dest != 2'h0)
    else $error("ch6 delivered while off");
endmodule
bind sec_rx_slot_map sec_rx_slot_map_chk u_sec_rx_slot_map_chk (.CORE_CLK_I, .NRST_I,
  .REG_ADDR_I, .REG_WE_I, .REG_WDATA_I, .REG_RDATA_O, .RX_VALID_O, .RX_WORD_O, .RX_READY_I);

// >>> tb/sec_rx_host_link.sv
module sec_rx_host_link (
  output logic bclk_o,
  output logic fsync_o,
  output logic din_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    bclk_o = 1'b0;
    fsync_o = 1'b0;
    din_o = 1'b0;
  end
  // 8 lead clocks let the format settle, then 32 slots msb first
  task automatic frame(input logic [1:0] f, input logic [31:0] w[32]);
    for (int n = -8; n < 1024; n++)
    begin
      if (f == 2'h1 && n >= -4)
        fsync_o = (n < 0) ? (n != -1) : (n >= 511);
      else if (f == 2'h2)
        fsync_o = (n >= 0 && n < 512);
      else if (f != 2'h1)
        fsync_o = (n == 0);
      din_o = (n < 0) ? ~din_o : w[n / 32][31 - n % 32];
      #24 bclk_o = 1'b1;
      #24 bclk_o = 1'b0;
    end
    din_o = ~din_o;
  endtask
endmodule

// >>> tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                          clk, nrst, we;
  logic [1:0]                    fmt;
  logic [2:0]                    rdy, vld;
  logic [7:0]                    addr, wdata, rdata, d;
  sec_rx_pkg::routed_word_t [2:0] word;
  wire                           bclk, fsync, din;
  int                            error_cnt, num_checks, cyc;
  int                            src[3], slot[3];
  logic [33:0]                   exp_q[3][$];
  logic [31:0]                   w[32];
  sec_rx_host_link u_sec_rx_host_link (.bclk_o(bclk), .fsync_o(fsync), .din_o(din));
  sec_rx_slot_map u_sec_rx_slot_map (.CORE_CLK_I(clk), .NRST_I(nrst), .BCLK_I(bclk),
    .FSYNC_I(fsync), .DIN_I(din), .FMT_I(fmt), .REG_ADDR_I(addr), .REG_WE_I(we),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .RX_VALID_O(vld), .RX_WORD_O(word),
    .RX_READY_I(rdy));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      close_out();
    end
  end
  // register read data against the model
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // routed word against the model
  task automatic cmp_word(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // words left over in the model after a drain
  task automatic cmp_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp)
    begin
      error_cnt++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    we <= 1'b1;
    wdata <= v;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(negedge clk);
    d = rdata;
  endtask
  // frames arrive while the receiver stalls, then everything is drained
  task automatic run(input logic [1:0] f, input int nfr);
    for (int i = 0; i < 3; i++)
      wr(8'(8'h2C + i), {1'b0, src[i][1:0], slot[i][4:0]});
    fmt <= f;
    repeat (nfr)
    begin
      foreach (w[k])
        w[k] = $urandom;
      for (int i = 0; i < 3; i++)
        if (src[i] != 0 && !(i == 0 && src[i] == 3))
          exp_q[i].push_back({src[i][1:0], w[slot[i]]});
      u_sec_rx_host_link.frame(f, w);
    end
    repeat (20) @(posedge clk);
    rdy <= 3'h7;
    repeat (12)
    begin
      @(negedge clk);
      for (int i = 0; i < 3; i++)
        if (vld[i] === 1'b1)
          cmp_word(word[i], exp_q[i].size() ? exp_q[i].pop_front() : 34'h0);
    end
    @(posedge clk);
    rdy <= 3'h0;
    for (int i = 0; i < 3; i++)
      cmp_cnt(exp_q[i].size(), 0);
    $display("test format %0d done", f);
  endtask
  initial
  begin
    nrst = 1'b0;
    we = 1'b0;
    addr = 8'h2C;
    wdata = 8'h00;
    fmt = 2'h0;
    rdy = 3'h0;
    void'($urandom(69));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      rd(8'(8'h2C + i));
      cmp_reg(d, 8'(8'h04 + i));
    end
    rd(8'h2F);
    cmp_reg(d, 8'h00);
    wr(8'h2C, 8'h7F);
    rd(8'h2C);
    cmp_reg(d, 8'h7F);
    $display("test registers done");
    for (int s = 0; s < 4; s++)
    begin
      foreach (src[i])
      begin
        src[i] = s;
        slot[i] = $urandom_range(31);
      end
      run(2'h0, 1);
    end
    src = '{1, 2, 3};
    slot = '{0, 16, 31};
    run(2'h2, 2);
    run(2'h1, 2);
    close_out();
  end
endmodule
